// file: design/ccw_control_word.v
// Codec control word: serial loading and decode into codec controls.
//
// Operation
// [R1] High byte first, then low byte.
// [R2] Host writes zero to high-byte bit 7.
// [R3] Direct access drives encoder data/clock out.
// [R4] Direct access takes decoder data/clock in.
// [R5] Direct access off: pins serve memory.
// [R6] Low bits 7:6 select store/play sync.
// [R7] Decoder 000: idle 32k, output filter.
// [R8] Decoder 001: idle 32k, audio bypass.
// [R9] Decoder 010: idle 32k, output high-Z.
// [R10] Decoder codes 011-111 set sampling rate.
// [R11] Encoder 000: input biased, idle 32k.
// [R12] Encoder 001: input high-Z, idle 32k.
// [R13] Encoder 010: input high-Z, idle 64k.
// [R14] Encoder codes 011-111 set rate independently.
// [R15] High bit 5 sets play count direction.
// [R16] High bit 4 disables memory control.
// [R17] High bit 3 powersaves codec, bias kept; the code drops output bias when decoder code is 001.
// [R18] High bits 2..0 enable completion interrupts.
// [R19] Word applied only after both bytes.
`timescale 1ns/1ps
`default_nettype none
`include "ccw_defs.vh"

module ccw_control_word #(
   parameter PRESCALE = 49
) (
   // Clock and reset
   input wire clk_sys,
   input wire resetn,
   // Serial control bus
   input wire bus_sclk,
   input wire bus_cs_n,
   input wire bus_data_in,
   // Shared address pins A0..A3
   input wire [3:0] pin_a_in,
   output reg [3:0] pin_a_out,
   output reg [3:0] pin_a_oe,
   // Memory sequencer side
   input wire [3:0] mem_addr_low,
   input wire mem_addr_oe,
   // Codec side
   input wire enc_bit,
   output reg enc_samp_clk,
   output reg dec_samp_clk,
   output reg dec_bit,
   // Decoded controls
   output reg direct_access,
   output reg play_count_down,
   output reg mem_ctrl_disable,
   output reg codec_powersave,
   output reg irq_en_store,
   output reg irq_en_play,
   output reg irq_en_power,
   output reg [1:0] sync_mode,
   output reg dec_force_idle,
   output reg audio_out_on,
   output reg audio_bypass_on,
   output reg output_bias_on,
   output reg enc_force_idle,
   output reg input_bias_on,
   output reg [15:0] word_out
);

   reg sclk_s1, sclk_s2, sclk_s3;
   reg cs_n_s1, cs_n_s2;
   reg din_s1, din_s2;
   reg [3:0] pin_s1, pin_s2;
   reg [7:0] shift_reg;
   reg [2:0] bit_reg;
   reg [1:0] byte_reg;
   reg [7:0] cmd_reg;
   reg [7:0] high_reg;
   reg [15:0] word_reg;
   wire sclk_rise;
   wire [7:0] byte_next;
   wire [2:0] dec_code;
   wire [2:0] enc_code;
   wire enc_clk_int, dec_clk_int;

   // Pin inputs are asynchronous to clk_sys.
   always @(posedge clk_sys) begin
      if (!resetn) begin
         sclk_s1 <= 1'b0;
         sclk_s2 <= 1'b0;
         sclk_s3 <= 1'b0;
         cs_n_s1 <= 1'b1;
         cs_n_s2 <= 1'b1;
         din_s1 <= 1'b0;
         din_s2 <= 1'b0;
      end else begin
         sclk_s1 <= bus_sclk;
         sclk_s2 <= sclk_s1;
         sclk_s3 <= sclk_s2;
         cs_n_s1 <= bus_cs_n;
         cs_n_s2 <= cs_n_s1;
         din_s1 <= bus_data_in;
         din_s2 <= din_s1;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin_sync
         always @(posedge clk_sys) begin
            if (!resetn) begin
               pin_s1[gi] <= 1'b0;
               pin_s2[gi] <= 1'b0;
            end else begin
               pin_s1[gi] <= pin_a_in[gi];
               pin_s2[gi] <= pin_s1[gi];
            end
         end
      end
   endgenerate

   assign sclk_rise = sclk_s2 & ~sclk_s3;
   assign byte_next = {shift_reg[6:0], din_s2};

   // Bytes arrive most significant bit first; the first byte of a frame is the
   // command, the following bytes are its data.
   always @(posedge clk_sys) begin
      if (!resetn) begin
         shift_reg <= 8'h00;
         bit_reg <= 3'h0;
         byte_reg <= 2'h0;
         cmd_reg <= 8'h00;
         high_reg <= 8'h00;
         word_reg <= `CCW_WORD_RESET;
      end else if (cs_n_s2) begin
         bit_reg <= 3'h0;
         byte_reg <= 2'h0;
      end else if (sclk_rise) begin
         shift_reg <= byte_next;
         bit_reg <= bit_reg + 3'h1;
         if (bit_reg == `CCW_BITS_PER_BYTE) begin
            if (byte_reg != 2'h3) begin
               byte_reg <= byte_reg + 2'h1;
            end
            case (byte_reg)
               2'h0: begin
                  cmd_reg <= byte_next;
                  if (byte_next == `CCW_CMD_GENERAL_RESET) begin
                     word_reg <= `CCW_WORD_RESET;
                  end
               end
               2'h1: begin
                  if (cmd_reg == `CCW_CMD_CTRL_WRITE) begin
                     high_reg <= byte_next; // [R1]
                  end
               end
               2'h2: begin
                  // A frame cut after the high byte leaves the word untouched.
                  if (cmd_reg == `CCW_CMD_CTRL_WRITE) begin
                     word_reg <= {high_reg, byte_next}; // [R1] [R19]
                  end
               end
               default: begin
                  shift_reg <= byte_next;
               end
            endcase
         end
      end
   end

   assign dec_code = word_reg[`CCW_DEC_HI:`CCW_DEC_LO];
   assign enc_code = word_reg[`CCW_ENC_HI:`CCW_ENC_LO];

   // Idle codes run at 32k, except encoder code 010 which idles at 64k.
   function [8:0] ccw_ratio;
      input [2:0] code;
      input idle_fast;
      begin
         case (code)
            `CCW_CODE_16K: ccw_ratio = `CCW_RATIO_16K;
            `CCW_CODE_25K: ccw_ratio = `CCW_RATIO_25K;
            `CCW_CODE_32K: ccw_ratio = `CCW_RATIO_32K;
            `CCW_CODE_50K: ccw_ratio = `CCW_RATIO_50K;
            `CCW_CODE_64K: ccw_ratio = `CCW_RATIO_64K;
            `CCW_CODE_IDLE_C: ccw_ratio = idle_fast ? `CCW_RATIO_64K : `CCW_RATIO_32K;
            default: ccw_ratio = `CCW_RATIO_32K;
         endcase
      end
   endfunction

   ccw_rate_div #(
      .PRESCALE(PRESCALE)
   ) u_enc_div (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .run(~word_reg[`CCW_BIT_POWERSAVE]),
      .ratio(ccw_ratio(enc_code, 1'b1)), // [R11] [R12] [R13] [R14]
      .samp_clk(enc_clk_int),
      .samp_tick()
   );

   ccw_rate_div #(
      .PRESCALE(PRESCALE)
   ) u_dec_div (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .run(~word_reg[`CCW_BIT_POWERSAVE]),
      .ratio(ccw_ratio(dec_code, 1'b0)), // [R7] [R8] [R9] [R10]
      .samp_clk(dec_clk_int),
      .samp_tick()
   );

   // Decoded controls are registered so every output comes from a flip-flop.
   always @(posedge clk_sys) begin
      if (!resetn) begin
         direct_access <= 1'b0;
         play_count_down <= 1'b0;
         mem_ctrl_disable <= 1'b0;
         codec_powersave <= 1'b0;
         irq_en_store <= 1'b0;
         irq_en_play <= 1'b0;
         irq_en_power <= 1'b0;
         sync_mode <= 2'h0;
         dec_force_idle <= 1'b0;
         audio_out_on <= 1'b0;
         audio_bypass_on <= 1'b0;
         output_bias_on <= 1'b0;
         enc_force_idle <= 1'b0;
         input_bias_on <= 1'b0;
         word_out <= `CCW_WORD_RESET;
         pin_a_out <= 4'h0;
         pin_a_oe <= 4'h0;
         enc_samp_clk <= 1'b0;
         dec_samp_clk <= 1'b0;
         dec_bit <= 1'b0;
      end else begin
         word_out <= word_reg;
         direct_access <= word_reg[`CCW_BIT_DIRECT_ACCESS];
         play_count_down <= word_reg[`CCW_BIT_PLAY_DOWN]; // [R15]
         mem_ctrl_disable <= word_reg[`CCW_BIT_MEM_DISABLE]; // [R16]
         codec_powersave <= word_reg[`CCW_BIT_POWERSAVE]; // [R17]
         irq_en_store <= word_reg[`CCW_BIT_IRQ_STORE]; // [R18]
         irq_en_play <= word_reg[`CCW_BIT_IRQ_PLAY]; // [R18]
         irq_en_power <= word_reg[`CCW_BIT_IRQ_POWER]; // [R18]
         // Codes 00 and 01 both mean no synchronisation.
         sync_mode <= word_reg[`CCW_SYNC_HI] ? word_reg[`CCW_SYNC_HI:`CCW_SYNC_LO] : 2'h0; // [R6]
         dec_force_idle <= (dec_code < `CCW_CODE_16K); // [R7] [R8] [R9] [R10]
         audio_bypass_on <= (dec_code == `CCW_CODE_IDLE_B); // [R8]
         audio_out_on <= ~word_reg[`CCW_BIT_POWERSAVE] &&
                         (dec_code != `CCW_CODE_IDLE_B) &&
                         (dec_code != `CCW_CODE_IDLE_C); // [R7] [R9]
         // Powersave keeps the output biased, except with decoder code 001, so it comes back without a step.
         output_bias_on <= word_reg[`CCW_BIT_POWERSAVE] &&
                           (dec_code != `CCW_CODE_IDLE_B); // [R17]
         enc_force_idle <= (enc_code < `CCW_CODE_16K); // [R11] [R12] [R13]
         input_bias_on <= word_reg[`CCW_BIT_POWERSAVE] ||
                          (enc_code == `CCW_CODE_IDLE_A); // [R11] [R12]
         enc_samp_clk <= enc_clk_int;
         if (word_reg[`CCW_BIT_DIRECT_ACCESS]) begin
            // A1 and A2 are inputs from the external codec partner.
            pin_a_out <= {enc_clk_int, 2'b00, enc_bit}; // [R3]
            pin_a_oe <= 4'h9; // [R3] [R4]
            dec_bit <= pin_s2[1]; // [R4]
            dec_samp_clk <= pin_s2[2]; // [R4]
         end else begin
            pin_a_out <= mem_addr_low; // [R5]
            pin_a_oe <= {4{mem_addr_oe}}; // [R5]
            dec_bit <= 1'b0;
            dec_samp_clk <= dec_clk_int;
         end
      end
   end

endmodule // ccw_control_word

`default_nettype wire

// file: design/ccw_defs.vh
// Constants for the codec control word decoder.
`ifndef CCW_DEFS_VH
`define CCW_DEFS_VH

// Serial bus command bytes.
`define CCW_CMD_GENERAL_RESET 8'h01
`define CCW_CMD_CTRL_WRITE 8'h60

// Control word reset value.
`define CCW_WORD_RESET 16'h0000

// High byte fields (word bits 15..8).
`define CCW_BIT_DIRECT_ACCESS 14
`define CCW_BIT_PLAY_DOWN 13
`define CCW_BIT_MEM_DISABLE 12
`define CCW_BIT_POWERSAVE 11
`define CCW_BIT_IRQ_STORE 10
`define CCW_BIT_IRQ_PLAY 9
`define CCW_BIT_IRQ_POWER 8

// Low byte fields (word bits 7..0).
`define CCW_SYNC_HI 7
`define CCW_SYNC_LO 6
`define CCW_DEC_HI 5
`define CCW_DEC_LO 3
`define CCW_ENC_HI 2
`define CCW_ENC_LO 0

// Store/play synchronisation codes.
`define CCW_SYNC_PLAY_AFTER_STORE 2'h2
`define CCW_SYNC_STORE_AFTER_PLAY 2'h3

// Codec control codes.
`define CCW_CODE_IDLE_A 3'h0
`define CCW_CODE_IDLE_B 3'h1
`define CCW_CODE_IDLE_C 3'h2
`define CCW_CODE_16K 3'h3
`define CCW_CODE_25K 3'h4
`define CCW_CODE_32K 3'h5
`define CCW_CODE_50K 3'h6
`define CCW_CODE_64K 3'h7

// Crystal clock division ratios per sampling rate.
`define CCW_RATIO_16K 9'h100
`define CCW_RATIO_25K 9'h0A0
`define CCW_RATIO_32K 9'h080
`define CCW_RATIO_50K 9'h050
`define CCW_RATIO_64K 9'h040

// Serial byte assembly.
`define CCW_BITS_PER_BYTE 3'h7

`endif

// file: design/ccw_rate_div.v
// Sampling clock divider driven from the crystal-rate prescaler.
`timescale 1ns/1ps
`default_nettype none

module ccw_rate_div #(
   parameter PRESCALE = 49
) (
   // Clock and reset
   input wire clk_sys,
   input wire resetn,
   // Control
   input wire run,
   input wire [8:0] ratio,
   // Sampling clock
   output reg samp_clk,
   output reg samp_tick
);

   reg [15:0] pre_reg;
   reg [7:0] half_reg;
   wire pre_done;
   wire [7:0] half_ratio;

   assign pre_done = (pre_reg == PRESCALE[15:0] - 16'h0001);
   assign half_ratio = ratio[8:1];

   // The sampling clock toggles every half ratio of crystal cycles, so it stays
   // square for every ratio the control word offers (all are even).
   always @(posedge clk_sys) begin
      if (!resetn || !run) begin
         pre_reg <= 16'h0000;
         half_reg <= 8'h00;
         samp_clk <= 1'b0;
         samp_tick <= 1'b0;
      end else begin
         samp_tick <= 1'b0;
         if (pre_done) begin
            pre_reg <= 16'h0000;
            if (half_reg >= half_ratio - 8'h01) begin
               half_reg <= 8'h00;
               samp_clk <= ~samp_clk;
               samp_tick <= ~samp_clk;
            end else begin
               half_reg <= half_reg + 8'h01;
            end
         end else begin
            pre_reg <= pre_reg + 16'h0001;
         end
      end
   end

endmodule // ccw_rate_div

`default_nettype wire

// file: sim/ccw_control_word_props.sv
// Concurrent checks on the control word decode and the shared pins.
`timescale 1ns/1ps
`default_nettype none
`include "ccw_defs.vh"
module ccw_control_word_chk #(
   parameter PRESCALE = 49
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Shared pins and codec side
   input wire logic [3:0] pin_a_in,
   input wire logic [3:0] pin_a_out,
   input wire logic [3:0] pin_a_oe,
   input wire logic [3:0] mem_addr_low,
   input wire logic mem_addr_oe,
   input wire logic enc_bit,
   input wire logic enc_samp_clk,
   input wire logic dec_samp_clk,
   input wire logic dec_bit,
   // Decoded controls
   input wire logic direct_access,
   input wire logic play_count_down,
   input wire logic mem_ctrl_disable,
   input wire logic codec_powersave,
   input wire logic irq_en_store,
   input wire logic irq_en_play,
   input wire logic irq_en_power,
   input wire logic [1:0] sync_mode,
   input wire logic dec_force_idle,
   input wire logic audio_out_on,
   input wire logic audio_bypass_on,
   input wire logic output_bias_on,
   input wire logic enc_force_idle,
   input wire logic input_bias_on,
   input wire logic [15:0] word_out
);
   // The decodes lag reset release by one edge, so decode checks wait two.
   logic [1:0] settle;
   always_ff @(posedge clk_sys) begin
      settle <= resetn ? {settle[0], 1'b1} : 2'h0;
   end
   // Half periods are judged only when the word stood still through the whole half.
   logic [15:0] word_prev;
   logic enc_prev, dec_prev, enc_clean, dec_clean;
   int enc_gap, dec_gap;
   always_ff @(posedge clk_sys) begin
      word_prev <= word_out;
      enc_prev <= enc_samp_clk;
      dec_prev <= dec_samp_clk;
      enc_gap <= (enc_samp_clk != enc_prev) ? 1 : enc_gap + 1;
      dec_gap <= (dec_samp_clk != dec_prev) ? 1 : dec_gap + 1;
      if (!resetn || enc_samp_clk != enc_prev) begin
         enc_clean <= resetn;
      end else if (word_out != word_prev) begin
         enc_clean <= 1'b0;
      end
      if (!resetn || dec_samp_clk != dec_prev) begin
         dec_clean <= resetn;
      end else if (word_out != word_prev) begin
         dec_clean <= 1'b0;
      end
   end
   // Sampling clock half period in clk_sys cycles for one codec code.
   function automatic int half_cyc(input logic [2:0] code, input logic idle_fast);
      int r;
      case (code)
         3'h3: r = `CCW_RATIO_16K;
         3'h4: r = `CCW_RATIO_25K;
         3'h5: r = `CCW_RATIO_32K;
         3'h6: r = `CCW_RATIO_50K;
         3'h7: r = `CCW_RATIO_64K;
         3'h2: r = idle_fast ? `CCW_RATIO_64K : `CCW_RATIO_32K;
         default: r = `CCW_RATIO_32K;
      endcase
      return r / 2 * PRESCALE;
   endfunction
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   AST_HI_BITS: assert property (settle[1] |-> {direct_access, play_count_down,
      mem_ctrl_disable, codec_powersave, irq_en_store, irq_en_play, irq_en_power}
      == word_out[14:8]) else $error("high control bits differ from word");
   AST_SYNC: assert property (settle[1] |->
      sync_mode == (word_out[7] ? word_out[7:6] : 2'h0)) else $error("sync decode wrong");
   AST_DEC_IDLE: assert property (settle[1] |->
      dec_force_idle == (word_out[5:3] < 3'h3)) else $error("decoder idle wrong");
   AST_ENC_IDLE: assert property (settle[1] |->
      enc_force_idle == (word_out[2:0] < 3'h3)) else $error("encoder idle wrong");
   AST_BYPASS: assert property (settle[1] |->
      audio_bypass_on == (word_out[5:3] == 3'h1)) else $error("bypass switch wrong");
   AST_AUDIO: assert property (settle[1] |->
      audio_out_on == (!codec_powersave && word_out[5:3] != 3'h1 && word_out[5:3] != 3'h2))
      else $error("audio out switch wrong");
   AST_IN_BIAS: assert property (settle[1] |->
      input_bias_on == (codec_powersave || word_out[2:0] == 3'h0))
      else $error("input bias switch wrong");
   AST_DA_PINS: assert property (settle[1] && direct_access |-> pin_a_oe == 4'h9)
      else $error("direct pin enables wrong");
   AST_DA_DEC: assert property (direct_access && $past(direct_access, 4) |->
      dec_bit == $past(pin_a_in[1], 3) && dec_samp_clk == $past(pin_a_in[2], 3))
      else $error("decoder data or clock not from pin");
   AST_DA_ENC: assert property (settle[1] && direct_access |-> pin_a_out[0] == $past(enc_bit)
      && pin_a_out[3] == enc_samp_clk && pin_a_out[2:1] == 2'b00)
      else $error("encoder data or clock not on pins");
   AST_NORMAL_PINS: assert property (settle[1] && !direct_access |->
      pin_a_oe == {4{$past(mem_addr_oe)}} && pin_a_out == $past(mem_addr_low))
      else $error("memory pins not passed through");
   AST_OUT_BIAS: assert property (settle[1] |->
      output_bias_on == (codec_powersave && word_out[5:3] != 3'h1))
      else $error("output bias switch wrong");
   AST_PS_STILL: assert property (settle[1] && codec_powersave && $past(codec_powersave) |->
      !enc_samp_clk && (direct_access || !dec_samp_clk))
      else $error("sample clocks run in powersave");
   AST_ENC_RATE: assert property (settle[1] && enc_clean && enc_samp_clk != enc_prev |->
      enc_gap == half_cyc(word_prev[2:0], 1'b1)) else $error("encoder sample rate wrong");
   AST_DEC_RATE: assert property (settle[1] && dec_clean && !direct_access
      && dec_samp_clk != dec_prev |-> dec_gap == half_cyc(word_prev[5:3], 1'b0))
      else $error("decoder sample rate wrong");
   C_DIRECT: cover property ($rose(direct_access));
   C_SYNC: cover property (sync_mode == 2'h3);
   C_PS_BYPASS: cover property (codec_powersave && audio_bypass_on);
endmodule // ccw_control_word_chk
bind ccw_control_word ccw_control_word_chk #(.PRESCALE(PRESCALE)) u_chk (.*);
`default_nettype wire

// file: sim/ccw_host.sv
// Host model that sends frames on the serial control bus.
`timescale 1ns/1ps
`default_nettype none
module ccw_host (
   // Serial control bus
   output logic bus_sclk,
   output logic bus_cs_n,
   output logic bus_data_in
);
   initial begin
      bus_sclk = 1'b0;
      bus_cs_n = 1'b1;
      bus_data_in = 1'b0;
   end
   // The link clock stands low between frames; data turns over while it is low.
   task automatic frame(input logic [7:0] cmd, input logic [15:0] w, input int nbytes);
      logic [23:0] v;
      v = {cmd, w};
      bus_cs_n = 1'b0;
      for (int i = 23; i > 15 - 8 * nbytes; i--) begin
         bus_data_in = v[i];
         #32 bus_sclk = 1'b1;
         #32 bus_sclk = 1'b0;
      end
      #32 bus_cs_n = 1'b1;
      // A released line must not keep looking like valid data.
      bus_data_in = ~bus_data_in;
      #64;
   endtask
endmodule // ccw_host
`default_nettype wire

// file: sim/ccw_control_word_tb.sv
// Self-checking bench for the codec control word decoder.
`timescale 1ns/1ps
`default_nettype none
`include "ccw_defs.vh"
module ccw_control_word_tb;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [3:0] pin_a_in = 4'h0;
   logic [3:0] mem_addr_low = 4'h0;
   logic mem_addr_oe = 1'b0;
   logic enc_bit = 1'b0;
   wire logic bus_sclk, bus_cs_n, bus_data_in, dec_force_idle, enc_force_idle;
   wire logic [3:0] pin_a_out, pin_a_oe;
   wire logic [1:0] sync_mode;
   wire logic [15:0] word_out;
   int fail_count = 0;
   int n_checks = 0;
   logic [15:0] exp_q[$];
   logic [15:0] ew;
   logic [15:0] lw = 16'h0000;
   logic [15:0] w;

   always #2.5 clk_sys = ~clk_sys;

   ccw_host u_host (.bus_sclk, .bus_cs_n, .bus_data_in);
   ccw_control_word #(.PRESCALE(2)) dut (.clk_sys, .resetn, .bus_sclk, .bus_cs_n,
      .bus_data_in, .pin_a_in, .pin_a_out, .pin_a_oe, .mem_addr_low, .mem_addr_oe,
      .enc_bit, .enc_samp_clk(), .dec_samp_clk(), .dec_bit(), .direct_access(),
      .play_count_down(), .mem_ctrl_disable(), .codec_powersave(), .irq_en_store(),
      .irq_en_play(), .irq_en_power(), .sync_mode, .dec_force_idle, .audio_out_on(),
      .audio_bypass_on(), .output_bias_on(), .enc_force_idle, .input_bias_on(),
      .word_out);

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      n_checks++;
      if (s !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic summarize();
      $display("Checks %0d, mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [15:0] v);
      exp_q.push_back(v);
      lw = v;
      u_host.frame(`CCW_CMD_CTRL_WRITE, v, 2);
      repeat (10) @(negedge clk_sys);
   endtask

   // The far side feeds decoder data and clock on the shared pins at random.
   always @(negedge clk_sys) begin
      pin_a_in <= 4'($urandom);
      enc_bit <= 1'($urandom);
      mem_addr_low <= 4'($urandom);
      mem_addr_oe <= 1'($urandom);
   end

   // Each applied word is matched against the oldest write still pending.
   always @(word_out) begin
      #1;
      if (resetn === 1'b1) begin
         ew = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hXXXX;
         chk("word_out", ew, word_out);
         chk("sync_mode", {14'h0, ew[7] ? ew[7:6] : 2'h0}, {14'h0, sync_mode});
         chk("idle", {14'h0, ew[5:3] < 3'h3, ew[2:0] < 3'h3},
            {14'h0, dec_force_idle, enc_force_idle});
      end
   end

   initial begin
      void'($urandom(74963));
      repeat (4) @(negedge clk_sys);
      resetn = 1'b1;
      repeat (2) @(negedge clk_sys);
      chk("word_reset", 16'h0000, word_out);
      for (int i = 0; i < 8; i++) begin
         w = {2'b00, 6'($urandom), 2'(i), 3'(i), 3'(7 - i)};
         wr(w);
      end
      u_host.frame(`CCW_CMD_CTRL_WRITE, 16'h7FFF, 1);
      u_host.frame(8'h33, 16'h1234, 2);
      repeat (10) @(negedge clk_sys);
      chk("word_kept", lw, word_out);
      wr(16'h5038);
      repeat (30) @(negedge clk_sys);
      chk("pin_oe", 16'h0009, {12'h0, pin_a_oe});
      chk("pin_out_mid", 16'h0000, {12'h0, pin_a_out & 4'h6});
      wr(16'h0808);
      wr(16'h00FF);
      exp_q.push_back(16'h0000);
      u_host.frame(`CCW_CMD_GENERAL_RESET, 16'h0000, 0);
      repeat (10) @(negedge clk_sys);
      chk("pending", 16'h0000, 16'(exp_q.size()));
      summarize();
   end

   initial begin
      #200000;
      fail_count++;
      summarize();
   end
endmodule // ccw_control_word_tb
`default_nettype wire
